// ### src/dcs_pkg.sv
// Summary of operation
// - request command counts selected source edges up to a startup limit.
// - clock ready flag sets when the availability counter reaches its limit.
// - clock ready flag clears when a new availability count begins.
// - once set, clock ready flag holds until a new count is commanded.
// - enable source command also starts the availability count.
// - recover copies the running system source code into source select field.
// - switch accepts RC, watchdog osc, external clock, low-freq and crystal.
// - at most one of the three external sources is enabled at a time.
// - external clock and low-freq enables are shared with the async timer.
// - command codes: disable 01, enable 02, switch 04, recover 05.
// - a command is taken only if the last command-address write was change-enable-only.
// - auto-reload watchdog command wins over the standard watchdog enable.
// - in auto-reload mode the watchdog only resets, never interrupts.
// - watchdog prescale bits set the timeout in both modes.
// - auto-reload mode, once armed, stays on until a reset.
// - auto-reload keeps the watchdog reloaded only if sysclk >= 4x watchdog osc.
// - software reload and hardware auto-reload are mutually exclusive.
// - disable command is ignored for the source driving the system clock.
// - reset loads source, startup and clock output fields from low fuses.
package dcs_pkg;
	localparam int         AW          = 2;
	localparam logic [1:0] ADDR_CMD    = 2'h0;
	localparam logic [1:0] ADDR_SEL    = 2'h1;
	localparam logic [1:0] ADDR_WDT    = 2'h2;
	localparam logic [7:0] CCE_ONLY    = 8'h80;
	localparam int         BIT_UNLOCK  = 7;
	localparam int         BIT_BUSY    = 5;
	localparam int         BIT_READY   = 4;
	localparam logic [7:0] CMD_DISABLE = 8'h01;
	localparam logic [7:0] CMD_ENABLE  = 8'h02;
	localparam logic [7:0] CMD_REQUEST = 8'h03;
	localparam logic [7:0] CMD_SWITCH  = 8'h04;
	localparam logic [7:0] CMD_RECOVER = 8'h05;
	localparam logic [7:0] CMD_WD_ARL  = 8'h06;
	localparam logic [3:0] SRC_EXT     = 4'h0;
	localparam logic [3:0] SRC_RC      = 4'h2;
	localparam logic [3:0] SRC_WD      = 4'h3;
	localparam logic [3:0] SRC_LF      = 4'h6;
	localparam logic [3:0] SRC_XTAL    = 4'h8;
	localparam logic [2:0] IDX_RC      = 3'h0;
	localparam logic [2:0] IDX_WD      = 3'h1;
	localparam logic [2:0] IDX_EXT     = 3'h2;
	localparam logic [2:0] IDX_LF      = 3'h3;
	localparam logic [2:0] IDX_XTAL    = 3'h4;
	localparam logic [2:0] IDX_NONE    = 3'h7;
	localparam int         SEL_START_LO = 4;
	localparam int         SEL_COUT    = 6;
	localparam int         WDT_P3      = 5;
	localparam int         WDT_WDE     = 3;
	localparam int         WDT_WDIE    = 6;
	localparam logic [3:0] WDT_P_MAX   = 4'h9;
	localparam logic [2:0] ARL_EDGES   = 3'h4;
	localparam int         WDT_W       = 21;
	localparam int         LIM_W       = 16;
	localparam int         LIM_CSUT0   = 6;
	localparam int         LIM_CSUT1   = 1024;
	localparam int         LIM_CSUT2   = 32768;
	localparam int         LIM_CSUT3   = 1024;
	localparam int         WDT_BASE    = 2048;
endpackage : dcs_pkg

// ### src/dcs_cnt_if.sv
`timescale 1ns/1ps
interface dcs_cnt_if #(parameter int LW = 16);
	logic          start;
	logic          tick;
	logic [LW-1:0] limit;
	logic          ready;
	logic          busy;
	modport ctl (output start, tick, limit, input ready, busy);
	modport cnt (input start, tick, limit, output ready, busy);
endinterface : dcs_cnt_if

// ### src/dcs_osc_counter.sv
`timescale 1ns/1ps
module dcs_osc_counter
	import dcs_pkg::*;
#(
	parameter int LW = LIM_W
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// control from the switch block
	dcs_cnt_if.cnt   cif
);
	typedef enum logic {CS_IDLE, CS_RUN} dcs_cst_e;
	typedef struct packed {
		dcs_cst_e      st;
		logic [LW-1:0] cnt;
		logic          ready;
	} dcs_cnt_s;

	dcs_cnt_s cnt_reg;
	dcs_cnt_s cnt_next;

	initial begin
		if (LW < 2) $error("counter width too small");
	end

	always_comb begin
		cnt_next = cnt_reg;
		case (cnt_reg.st)
			CS_IDLE: begin
			end
			CS_RUN: begin
				if (cif.tick) begin
					if (cnt_reg.cnt == cif.limit - LW'(1)) begin
						cnt_next.ready = 1'b1;
						cnt_next.st    = CS_IDLE;
					end else begin
						cnt_next.cnt = cnt_reg.cnt + LW'(1);
					end
				end
			end
			default: cnt_next.st = CS_IDLE;
		endcase
		// a new request restarts even a running count
		if (cif.start) begin
			cnt_next.st    = CS_RUN;
			cnt_next.cnt   = '0;
			cnt_next.ready = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '{st: CS_IDLE, cnt: '0, ready: 1'b0};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign cif.ready = cnt_reg.ready;
	assign cif.busy  = (cnt_reg.st == CS_RUN);

	default clocking dcs_cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_ready_clears: assert property (cif.start |=> !cif.ready && cif.busy)
		else $error("ready not cleared at count start");
	a_ready_sets: assert property (cif.busy && cif.tick && !cif.start
		&& cnt_reg.cnt == cif.limit - LW'(1) |=> cif.ready)
		else $error("ready not set at count limit");
	a_ready_holds: assert property (cif.ready && !cif.start |=> cif.ready)
		else $error("ready dropped without new count");
endmodule : dcs_osc_counter

// ### src/dcs_clock_switch.sv
`timescale 1ns/1ps
module dcs_clock_switch
	import dcs_pkg::*;
#(
	parameter int LIM0     = LIM_CSUT0,
	parameter int LIM1     = LIM_CSUT1,
	parameter int LIM2     = LIM_CSUT2,
	parameter int LIM3     = LIM_CSUT3,
	parameter int WDT_TICK = WDT_BASE
) (
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_n_i,
	// register port
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [7:0]    rdata_o,
	// fuses and oscillators
	input  wire logic [7:0]    fuse_low_i,
	input  wire logic [4:0]    src_clk_i,
	input  wire logic [1:0]    asy_en_req_i,
	input  wire logic          wdr_i,
	// clock control outputs
	output logic      [4:0]    src_en_o,
	output logic      [3:0]    sys_sel_o,
	output logic               clk_out_en_o,
	output logic               clk_ready_o,
	output logic               wdt_rst_o,
	output logic               wdt_irq_o
);
	typedef struct packed {
		logic             unlock;
		logic [3:0]       sel_src;
		logic [1:0]       sel_start;
		logic             cout;
		logic [4:0]       en;
		logic [3:0]       sys_sel;
		logic [2:0]       cnt_idx;
		logic             start;
		logic [3:0]       wdt_p;
		logic             wde;
		logic             wdie;
		logic             arl;
		logic [WDT_W-1:0] wdt_cnt;
		logic [2:0]       sys_edges;
		logic             wdt_rst;
		logic             wdt_irq;
		logic [7:0]       rdata;
		logic [4:0]       src_prev;
	} dcs_state_s;

	dcs_state_s st_reg;
	dcs_state_s st_next;
	dcs_state_s st_rst;

	dcs_cnt_if #(.LW(LIM_W)) cif ();

	initial begin
		if (LIM0 < 1 || LIM1 < 1 || LIM2 < 1 || LIM3 < 1)
			$error("startup count limits must be positive");
		if (LIM0 >= 2**LIM_W || LIM1 >= 2**LIM_W || LIM2 >= 2**LIM_W
			|| LIM3 >= 2**LIM_W)
			$error("startup count limit too wide");
		if (WDT_TICK < 1 || WDT_TICK >= 2**(WDT_W - 9))
			$error("watchdog base period out of range");
	end

	function automatic logic [2:0] src_index(input logic [3:0] code);
		case (code)
			SRC_RC:   src_index = IDX_RC;
			SRC_WD:   src_index = IDX_WD;
			SRC_EXT:  src_index = IDX_EXT;
			SRC_LF:   src_index = IDX_LF;
			SRC_XTAL: src_index = IDX_XTAL;
			default:  src_index = IDX_NONE;
		endcase
	endfunction : src_index

	function automatic logic pick(input logic [4:0] v, input logic [2:0] i);
		pick = (i <= IDX_XTAL) ? v[i] : 1'b0;
	endfunction : pick

	// only one external source may run; the new one wins
	function automatic logic [4:0] ext_only(input logic [4:0] en,
		input logic [2:0] i);
		logic [4:0] r;
		r = en;
		if (i >= IDX_EXT && i <= IDX_XTAL) begin
			r[IDX_XTAL:IDX_EXT] = '0;
		end
		r[i] = 1'b1;
		ext_only = r;
	endfunction : ext_only

	logic [4:0]       rise;
	logic [2:0]       sel_idx;
	logic             cmd_go;
	logic [WDT_W-1:0] wdt_lim;
	logic [3:0]       wdt_p_eff;
	logic             wd_tick;
	logic             wdt_act;
	logic             reload;

	assign rise      = src_clk_i & ~st_reg.src_prev;
	assign sel_idx   = src_index(st_reg.sel_src);
	assign cmd_go    = wr_i && addr_i == ADDR_CMD && st_reg.unlock
		&& wdata_i != CCE_ONLY;
	assign wd_tick   = rise[IDX_WD];
	assign wdt_p_eff = (st_reg.wdt_p > WDT_P_MAX) ? WDT_P_MAX : st_reg.wdt_p;
	assign wdt_lim   = WDT_W'(WDT_TICK) << wdt_p_eff;
	assign wdt_act   = st_reg.arl || st_reg.wde || st_reg.wdie;

	assign cif.start = st_reg.start;
	assign cif.tick  = pick(rise, st_reg.cnt_idx);
	always_comb begin
		case (st_reg.sel_start)
			2'h0:    cif.limit = LIM_W'(LIM0);
			2'h1:    cif.limit = LIM_W'(LIM1);
			2'h2:    cif.limit = LIM_W'(LIM2);
			default: cif.limit = LIM_W'(LIM3);
		endcase
	end

	dcs_osc_counter #(.LW(LIM_W)) u_cnt (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.cif     (cif)
	);

	// fuse image at reset; the fused source is the running system clock
	always_comb begin
		st_rst          = '0;
		st_rst.sel_src   = fuse_low_i[3:0];
		st_rst.sel_start = fuse_low_i[5:4];
		st_rst.cout     = ~fuse_low_i[SEL_COUT];
		st_rst.sys_sel  = fuse_low_i[3:0];
		st_rst.en       = ext_only(5'h00, src_index(fuse_low_i[3:0]));
		st_rst.src_prev = src_clk_i;
		if (src_index(fuse_low_i[3:0]) == IDX_NONE) begin
			st_rst.en = 5'h01;
		end
	end

	always_comb begin
		st_next          = st_reg;
		st_next.start    = 1'b0;
		st_next.wdt_rst  = 1'b0;
		st_next.wdt_irq  = 1'b0;
		st_next.rdata    = 8'h00;
		st_next.src_prev = src_clk_i;
		reload           = 1'b0;

		if (wr_i) begin
			case (addr_i)
				ADDR_CMD: begin
					// any write other than the bare unlock relocks
					st_next.unlock = (wdata_i == CCE_ONLY);
				end
				ADDR_SEL: begin
					st_next.sel_src   = wdata_i[3:0];
					st_next.sel_start = wdata_i[SEL_START_LO +: 2];
					st_next.cout = wdata_i[SEL_COUT];
				end
				ADDR_WDT: begin
					st_next.wdt_p = {wdata_i[WDT_P3], wdata_i[2:0]};
					st_next.wde   = wdata_i[WDT_WDE];
					st_next.wdie  = wdata_i[WDT_WDIE];
				end
				default: begin
				end
			endcase
		end

		if (cmd_go) begin
			case (wdata_i)
				CMD_DISABLE: begin
					if (sel_idx != IDX_NONE
						&& st_reg.sel_src != st_reg.sys_sel) begin
						st_next.en[sel_idx] = 1'b0;
					end
				end
				CMD_ENABLE: begin
					if (sel_idx != IDX_NONE) begin
						st_next.en      = ext_only(st_reg.en, sel_idx);
						st_next.cnt_idx = sel_idx;
						st_next.start   = 1'b1;
					end
				end
				CMD_REQUEST: begin
					if (sel_idx != IDX_NONE) begin
						st_next.cnt_idx = sel_idx;
						st_next.start   = 1'b1;
					end
				end
				CMD_SWITCH: begin
					if (sel_idx != IDX_NONE) begin
						st_next.sys_sel = st_reg.sel_src;
					end
				end
				CMD_RECOVER: st_next.sel_src = st_reg.sys_sel;
				CMD_WD_ARL:  st_next.arl  = 1'b1;
				default: begin
				end
			endcase
		end

		// the async timer drives the same enable flops
		if (asy_en_req_i[0]) begin
			st_next.en = ext_only(st_next.en, IDX_EXT);
		end else if (asy_en_req_i[1]) begin
			st_next.en = ext_only(st_next.en, IDX_LF);
		end

		// auto reload needs ARL_EDGES sysclk edges per watchdog tick
		if (st_reg.arl) begin
			if (wd_tick) begin
				st_next.sys_edges = 3'h0;
			end else if (pick(rise, src_index(st_reg.sys_sel))) begin
				if (st_reg.sys_edges == ARL_EDGES - 3'h1) begin
					reload            = 1'b1;
					st_next.sys_edges = 3'h0;
				end else begin
					st_next.sys_edges = st_reg.sys_edges + 3'h1;
				end
			end
		end else begin
			reload = wdr_i && wdt_act;
		end

		if (!wdt_act || reload) begin
			st_next.wdt_cnt = '0;
		end else if (wd_tick) begin
			if (st_reg.wdt_cnt >= wdt_lim - WDT_W'(1)) begin
				st_next.wdt_cnt = '0;
				if (st_reg.arl || st_reg.wde) begin
					st_next.wdt_rst = 1'b1;
				end else begin
					st_next.wdt_irq = 1'b1;
				end
			end else begin
				st_next.wdt_cnt = st_reg.wdt_cnt + WDT_W'(1);
			end
		end

		if (rd_i) begin
			case (addr_i)
				ADDR_CMD: begin
					st_next.rdata[BIT_UNLOCK] = st_reg.unlock;
					st_next.rdata[BIT_BUSY]   = cif.busy;
					st_next.rdata[BIT_READY]  = cif.ready;
				end
				ADDR_SEL: st_next.rdata = {1'b0, st_reg.cout, st_reg.sel_start,
					st_reg.sel_src};
				ADDR_WDT: st_next.rdata = {1'b0, st_reg.wdie, st_reg.wdt_p[3],
					st_reg.arl, st_reg.wde, st_reg.wdt_p[2:0]};
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_reg <= st_rst;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o      = st_reg.rdata;
	assign src_en_o     = st_reg.en;
	assign sys_sel_o    = st_reg.sys_sel;
	assign clk_out_en_o = st_reg.cout;
	assign clk_ready_o  = cif.ready;
	assign wdt_rst_o    = st_reg.wdt_rst;
	assign wdt_irq_o    = st_reg.wdt_irq;

	default clocking dcs_cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_enable_starts: assert property (cmd_go && wdata_i == CMD_ENABLE
		&& sel_idx != IDX_NONE |-> ##2 cif.busy && !clk_ready_o)
		else $error("enable did not start availability count");
	a_locked_ignored: assert property (wr_i && addr_i == ADDR_CMD
		&& !st_reg.unlock |=> $stable(sys_sel_o))
		else $error("command taken without unlock");
	a_one_external: assert property ($countones(src_en_o[4:2]) <= 1)
		else $error("two external sources enabled");
	a_disable_current: assert property (cmd_go && wdata_i == CMD_DISABLE
		&& st_reg.sel_src == sys_sel_o && asy_en_req_i == 2'h0
		|=> $stable(src_en_o))
		else $error("running system source was disabled");
	a_switch_takes: assert property (cmd_go && wdata_i == CMD_SWITCH
		&& sel_idx != IDX_NONE |=> sys_sel_o == $past(st_reg.sel_src))
		else $error("switch did not select target");
	a_recover_copies: assert property (cmd_go && wdata_i == CMD_RECOVER
		|=> st_reg.sel_src == sys_sel_o)
		else $error("recover did not return system source");
	a_arl_sticky: assert property (st_reg.arl |=> st_reg.arl)
		else $error("auto reload mode dropped");
	a_arl_no_irq: assert property (st_reg.arl |=> !wdt_irq_o)
		else $error("interrupt raised in auto reload mode");
	a_arl_no_swreload: assert property (st_reg.arl && wdr_i && !wd_tick
		&& st_reg.wdt_cnt != '0 && !reload |=> st_reg.wdt_cnt != '0)
		else $error("software reload acted in auto reload mode");
endmodule : dcs_clock_switch

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import dcs_pkg::*;
	logic            mclk_i = 1'b0;
	logic            rst_n_i = 1'b0;
	logic [AW-1:0]   addr_i = '0;
	logic [7:0]      wdata_i = 8'h00;
	logic            wr_i = 1'b0;
	logic            rd_i = 1'b0;
	logic [7:0]      rdata_o;
	logic [7:0]      fuse_low_i = 8'h12;
	logic [4:0]      src_clk_i = 5'h00;
	logic [1:0]      asy_en_req_i = 2'h0;
	logic            wdr_i = 1'b0;
	logic [4:0]      src_en_o;
	logic [3:0]      sys_sel_o;
	logic            clk_out_en_o;
	logic            clk_ready_o;
	logic            wdt_rst_o;
	logic            wdt_irq_o;
	logic [4:0]      run_m = 5'h00;
	logic [4:0]      man_v = 5'h00;
	logic [3:0]      dcnt = 4'h0;
	logic [7:0]      rv;
	logic [3:0]      codes [5];
	int              error_cnt = 0;
	int              total_checks = 0;
	int              n;
	int              hits;

	always #5 mclk_i = ~mclk_i;

	// watchdog osc runs 16x slower than the others so auto reload can work
	always @(posedge mclk_i) begin
		dcnt <= dcnt + 4'h1;
		src_clk_i <= ((src_clk_i ^ {3'h7, dcnt == 4'h0, 1'b1}) & run_m)
			| (man_v & ~run_m);
	end

	dcs_clock_switch #(
		.LIM0     (4),
		.LIM1     (5),
		.LIM2     (6),
		.LIM3     (7),
		.WDT_TICK (8)
	) dcs_clock_switch_i (
		.mclk_i       (mclk_i),
		.rst_n_i      (rst_n_i),
		.addr_i       (addr_i),
		.wdata_i      (wdata_i),
		.wr_i         (wr_i),
		.rd_i         (rd_i),
		.rdata_o      (rdata_o),
		.fuse_low_i   (fuse_low_i),
		.src_clk_i    (src_clk_i),
		.asy_en_req_i (asy_en_req_i),
		.wdr_i        (wdr_i),
		.src_en_o     (src_en_o),
		.sys_sel_o    (sys_sel_o),
		.clk_out_en_o (clk_out_en_o),
		.clk_ready_o  (clk_ready_o),
		.wdt_rst_o    (wdt_rst_o),
		.wdt_irq_o    (wdt_irq_o)
	);

	task complete_run;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task wr(input logic [AW-1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [AW-1:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd

	task cmd(input logic [7:0] c);
		wr(ADDR_CMD, CCE_ONLY);
		wr(ADDR_CMD, c);
	endtask : cmd

	task pulse(input int i, input int cnt);
		repeat (cnt) begin
			@(posedge mclk_i);
			man_v[i] <= 1'b1;
			@(posedge mclk_i);
			man_v[i] <= 1'b0;
		end
		repeat (4) @(posedge mclk_i);
		#1;
	endtask : pulse

	// k: 0 ready, 1 system source equals c, 2 irq pulse, 3 reset pulse
	task wait_on(input int k, input logic [3:0] c, input int lim);
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < lim) begin
			@(posedge mclk_i);
			#1;
			n++;
			hit = k == 0 ? clk_ready_o === 1'b1 : k == 1 ? sys_sel_o === c
				: k == 2 ? wdt_irq_o === 1'b1 : wdt_rst_o === 1'b1;
		end
		chk("wait event", 8'h01, {7'h00, hit});
	endtask : wait_on

	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end

	initial begin
		codes = '{SRC_XTAL, SRC_LF, SRC_EXT, SRC_WD, SRC_RC};
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(ADDR_SEL, rv);
		chk("sel after reset", 8'h52, rv);
		chk("sys source", {4'h0, SRC_RC}, {4'h0, sys_sel_o});
		chk("enables", 8'h01, {3'h0, src_en_o});
		chk("clock out", 8'h01, {7'h00, clk_out_en_o});
		wr(2'h3, 8'hFF);
		rd(2'h3, rv);
		chk("unmapped", 8'h00, rv);
		// command without unlock must do nothing
		wr(ADDR_SEL, {4'h0, SRC_XTAL});
		wr(ADDR_CMD, CMD_ENABLE);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("locked enable", 8'h01, {3'h0, src_en_o});
		cmd(CMD_ENABLE);
		pulse(4, 3);
		chk("enabled", 8'h11, {3'h0, src_en_o});
		chk("ready early", 8'h00, {7'h00, clk_ready_o});
		pulse(4, 1);
		chk("ready at limit", 8'h01, {7'h00, clk_ready_o});
		pulse(4, 3);
		rd(ADDR_CMD, rv);
		chk("ready holds", 8'h01, {7'h00, rv[BIT_READY]});
		cmd(CMD_REQUEST);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("ready cleared", 8'h00, {7'h00, clk_ready_o});
		pulse(4, 4);
		chk("ready again", 8'h01, {7'h00, clk_ready_o});
		run_m <= 5'h1F;
		foreach (codes[k]) begin
			wr(ADDR_SEL, {4'h0, codes[k]});
			cmd(CMD_ENABLE);
			wait_on(0, 4'h0, 200);
			chk("one external", 8'h01,
				{7'h00, $countones(src_en_o[4:2]) <= 1});
			cmd(CMD_SWITCH);
			wait_on(1, codes[k], 200);
			wr(ADDR_SEL, 8'h0F);
			cmd(CMD_RECOVER);
			rd(ADDR_SEL, rv);
			chk("recovered", {4'h0, codes[k]}, {4'h0, rv[3:0]});
		end
		wr(ADDR_SEL, {4'h0, SRC_RC});
		cmd(CMD_DISABLE);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("current kept", 8'h01, {7'h00, src_en_o[0]});
		wr(ADDR_SEL, {4'h0, SRC_EXT});
		cmd(CMD_DISABLE);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("ext disabled", 8'h00, {7'h00, src_en_o[2]});
		@(posedge mclk_i);
		asy_en_req_i <= 2'h2;
		repeat (3) @(posedge mclk_i);
		#1;
		chk("timer lf enable", 8'h01, {7'h00, src_en_o[3]});
		@(posedge mclk_i);
		asy_en_req_i <= 2'h0;
		// interrupt only: eight ticks of 32 cycles each
		wr(ADDR_WDT, 8'h40);
		wait_on(2, 4'h0, 400);
		chk("timeout span", 8'h01, {7'h00, n > 200 && n < 300});
		wr(ADDR_WDT, 8'h00);
		cmd(CMD_WD_ARL);
		wr(ADDR_WDT, 8'h40);
		wr(ADDR_WDT, 8'h00);
		rd(ADDR_WDT, rv);
		chk("auto reload on", 8'h01, {7'h00, rv[4]});
		hits = 0;
		repeat (700) begin
			@(posedge mclk_i);
			wdr_i <= 1'b1;
			#1;
			hits += wdt_irq_o + wdt_rst_o;
		end
		@(posedge mclk_i);
		wdr_i <= 1'b0;
		chk("no event running", 8'h00, {7'h00, hits != 0});
		// stopping the system source must end in a watchdog reset
		run_m <= 5'h1E;
		wait_on(3, 4'h0, 500);
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(ADDR_WDT, rv);
		chk("auto reload reset", 8'h00, {7'h00, rv[4]});
		complete_run();
	end
endmodule : testbench
